// *** include/itap_pkg.sv ***
package itap_pkg;

  // ****************************************************************
  // bus and register widths
  // ****************************************************************
  localparam int ITAP_ADDR_W = 12;
  localparam int ITAP_DATA_W = 32;
  localparam int ITAP_REG_W = 16;
  localparam int ITAP_ENTRY_W = 67;
  localparam int ITAP_INDEX_W = 10;
  localparam int ITAP_TOP_W = 3;

  // ****************************************************************
  // register indices as printed; byte address is four times the index
  // ****************************************************************
  localparam logic [ITAP_ADDR_W-1:0] ITAP_IDX_DATA_TOP = 12'h026;
  localparam logic [ITAP_ADDR_W-1:0] ITAP_IDX_DATA_47_32 = 12'h028;
  localparam logic [ITAP_ADDR_W-1:0] ITAP_IDX_DATA_63_48 = 12'h02A;
  localparam logic [ITAP_ADDR_W-1:0] ITAP_IDX_DATA_15_0 = 12'h02C;
  localparam logic [ITAP_ADDR_W-1:0] ITAP_IDX_DATA_31_16 = 12'h02E;
  localparam logic [ITAP_ADDR_W-1:0] ITAP_IDX_COMMAND = 12'h030;
  localparam int ITAP_BYTE_SHIFT = 2;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ITAP_CMD_DIR_BIT = 12;
  localparam int ITAP_CMD_TBL_HI = 11;
  localparam int ITAP_CMD_TBL_LO = 10;
  localparam int ITAP_CMD_IDX_HI = 9;
  localparam int ITAP_CMD_IDX_LO = 0;
  localparam int ITAP_STAT_PEND_BIT = 7;
  localparam int ITAP_STAT_TOP_HI = 2;
  localparam int ITAP_STAT_TOP_LO = 0;
  localparam int ITAP_SLICE_0_LO = 0;
  localparam int ITAP_SLICE_1_LO = 16;
  localparam int ITAP_SLICE_2_LO = 32;
  localparam int ITAP_SLICE_3_LO = 48;
  localparam int ITAP_SLICE_TOP_LO = 64;

  // ****************************************************************
  // reset values and encodings
  // ****************************************************************
  localparam logic [ITAP_REG_W-1:0] ITAP_REG_RESET = 16'h0000;
  localparam logic [ITAP_TOP_W-1:0] ITAP_TOP_RESET = 3'h0;
  localparam logic [ITAP_DATA_W-1:0] ITAP_RDATA_ZERO = 32'h00000000;
  localparam logic ITAP_DIR_READ = 1'b1;
  localparam logic ITAP_DIR_WRITE = 1'b0;

  typedef enum logic [1:0] {
    ITAP_TBL_STATIC = 2'h0,
    ITAP_TBL_VLAN = 2'h1,
    ITAP_TBL_DYNAMIC = 2'h2,
    ITAP_TBL_COUNTERS = 2'h3
  } itap_table_e;

  typedef enum {
    ITAP_IDLE,
    ITAP_WAIT
  } itap_state_e;

endpackage

// *** src/itap_indirect_table_access_port.sv ***
// What this block does
// - every software write to the command register launches exactly one table access.
// - command bit 12 picks the direction, one for a read and zero for a write.
// - command bits 11-10 pick static, vlan, dynamic or counter table as 00, 01, 10, 11.
// - command bits 9-0 give the entry or counter index of the launched access.
// - status bit 7 of the top data register is high while a dynamic or counter read is underway, low after.
// - only dynamic table and counter reads raise that pending bit.
// - entry bits 66-64 show as read-only bits 2-0 of the top data register.
// - the second data register holds entry bits 47-32, host written and read loaded.
// - the third data register holds entry bits 63-48, host written and read loaded.
// - the fourth data register holds entry bits 15-0, host written and read loaded.
// - the fifth data register holds entry bits 31-16, host written and read loaded.
`timescale 1ns/100ps
`default_nettype none
module itap_indirect_table_access_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [itap_pkg::ITAP_ADDR_W-1:0] paddr,
  input wire logic [itap_pkg::ITAP_DATA_W-1:0] pwdata,
  output logic [itap_pkg::ITAP_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tbl_req,
  output logic tbl_dir_read,
  output logic [1:0] tbl_select,
  output logic [itap_pkg::ITAP_INDEX_W-1:0] tbl_index,
  output logic [itap_pkg::ITAP_ENTRY_W-1:0] tbl_wdata,
  input wire logic tbl_ack,
  input wire logic [itap_pkg::ITAP_ENTRY_W-1:0] tbl_rdata
);
  import itap_pkg::*;

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [ITAP_REG_W-1:0] d15_0_reg;
  logic [ITAP_REG_W-1:0] d31_16_reg;
  logic [ITAP_REG_W-1:0] d47_32_reg;
  logic [ITAP_REG_W-1:0] d63_48_reg;
  logic [ITAP_TOP_W-1:0] top_reg;
  logic [ITAP_REG_W-1:0] command_reg;
  logic pending_reg;
  logic req_reg;
  logic dir_reg;
  logic [1:0] sel_reg;
  logic [ITAP_INDEX_W-1:0] idx_reg;
  logic [ITAP_DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  itap_state_e state_reg;

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic [ITAP_ADDR_W-1:0] a_top;
  logic [ITAP_ADDR_W-1:0] a_47_32;
  logic [ITAP_ADDR_W-1:0] a_63_48;
  logic [ITAP_ADDR_W-1:0] a_15_0;
  logic [ITAP_ADDR_W-1:0] a_31_16;
  logic [ITAP_ADDR_W-1:0] a_cmd;
  logic hit_top;
  logic hit_47_32;
  logic hit_63_48;
  logic hit_15_0;
  logic hit_31_16;
  logic hit_cmd;
  logic mapped;
  logic access_done;
  logic wr_done;
  logic launch;
  logic busy;
  logic stall;
  logic rd_done;
  logic [ITAP_REG_W-1:0] wdata16;
  logic [ITAP_DATA_W-1:0] rd_word;

  assign a_top = ITAP_IDX_DATA_TOP << ITAP_BYTE_SHIFT;
  assign a_47_32 = ITAP_IDX_DATA_47_32 << ITAP_BYTE_SHIFT;
  assign a_63_48 = ITAP_IDX_DATA_63_48 << ITAP_BYTE_SHIFT;
  assign a_15_0 = ITAP_IDX_DATA_15_0 << ITAP_BYTE_SHIFT;
  assign a_31_16 = ITAP_IDX_DATA_31_16 << ITAP_BYTE_SHIFT;
  assign a_cmd = ITAP_IDX_COMMAND << ITAP_BYTE_SHIFT;

  assign hit_top = (paddr == a_top);
  assign hit_47_32 = (paddr == a_47_32);
  assign hit_63_48 = (paddr == a_63_48);
  assign hit_15_0 = (paddr == a_15_0);
  assign hit_31_16 = (paddr == a_31_16);
  assign hit_cmd = (paddr == a_cmd);
  assign mapped = hit_top | hit_47_32 | hit_63_48 | hit_15_0 | hit_31_16 | hit_cmd;

  assign wdata16 = pwdata[ITAP_REG_W-1:0];
  assign access_done = psel & penable & pready_reg;
  assign wr_done = access_done & pwrite & ~pslverr_reg;
  assign launch = wr_done & hit_cmd;
  assign busy = (state_reg == ITAP_WAIT);
  assign rd_done = busy & tbl_ack & dir_reg;
  // a command write waits out a running access instead of being dropped
  assign stall = pwrite & hit_cmd & busy & ~tbl_ack;

  // unmapped addresses, bits 31-16 and unused status bits read as zero, whatever the direction; command bits 15-13 read back as written
  always_comb begin
    rd_word = ITAP_RDATA_ZERO;
    if (hit_top) begin
      rd_word[ITAP_STAT_PEND_BIT] = pending_reg;
      rd_word[ITAP_STAT_TOP_HI:ITAP_STAT_TOP_LO] = top_reg;
    end
    if (hit_47_32) begin
      rd_word[ITAP_REG_W-1:0] = d47_32_reg;
    end
    if (hit_63_48) begin
      rd_word[ITAP_REG_W-1:0] = d63_48_reg;
    end
    if (hit_15_0) begin
      rd_word[ITAP_REG_W-1:0] = d15_0_reg;
    end
    if (hit_31_16) begin
      rd_word[ITAP_REG_W-1:0] = d31_16_reg;
    end
    if (hit_cmd) begin
      rd_word[ITAP_REG_W-1:0] = command_reg;
    end
  end

  // ****************************************************************
  // apb answer, no wait state except a stalled command write; unmapped addresses answer with pslverr
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= psel & ~access_done & ~stall;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else if (psel & ~penable) begin
      pslverr_reg <= ~mapped;
    end else if (access_done) begin
      pslverr_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= ITAP_RDATA_ZERO;
    end else if (psel & ~access_done) begin
      prdata_reg <= rd_word;
    end
  end

  // ****************************************************************
  // staging registers, four identical host-written slices
  // ****************************************************************
  itap_stage_slice #(
    .W(ITAP_REG_W),
    .RESET_VALUE(ITAP_REG_RESET)
  ) stage_47_32_inst (
    .pclk(pclk),
    .presetn(presetn),
    .rd_load(rd_done),
    .rd_value(tbl_rdata[ITAP_SLICE_2_LO +: ITAP_REG_W]),
    .wr_load(wr_done & hit_47_32),
    .wr_value(wdata16),
    .value(d47_32_reg)
  );

  itap_stage_slice #(
    .W(ITAP_REG_W),
    .RESET_VALUE(ITAP_REG_RESET)
  ) stage_63_48_inst (
    .pclk(pclk),
    .presetn(presetn),
    .rd_load(rd_done),
    .rd_value(tbl_rdata[ITAP_SLICE_3_LO +: ITAP_REG_W]),
    .wr_load(wr_done & hit_63_48),
    .wr_value(wdata16),
    .value(d63_48_reg)
  );

  itap_stage_slice #(
    .W(ITAP_REG_W),
    .RESET_VALUE(ITAP_REG_RESET)
  ) stage_15_0_inst (
    .pclk(pclk),
    .presetn(presetn),
    .rd_load(rd_done),
    .rd_value(tbl_rdata[ITAP_SLICE_0_LO +: ITAP_REG_W]),
    .wr_load(wr_done & hit_15_0),
    .wr_value(wdata16),
    .value(d15_0_reg)
  );

  itap_stage_slice #(
    .W(ITAP_REG_W),
    .RESET_VALUE(ITAP_REG_RESET)
  ) stage_31_16_inst (
    .pclk(pclk),
    .presetn(presetn),
    .rd_load(rd_done),
    .rd_value(tbl_rdata[ITAP_SLICE_1_LO +: ITAP_REG_W]),
    .wr_load(wr_done & hit_31_16),
    .wr_value(wdata16),
    .value(d31_16_reg)
  );

  // top bits move only on a read; host writes to that register are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_reg <= ITAP_TOP_RESET;
    end else if (rd_done) begin
      top_reg <= tbl_rdata[ITAP_SLICE_TOP_LO +: ITAP_TOP_W];
    end
  end

  // ****************************************************************
  // command register and launch
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_reg <= ITAP_REG_RESET;
    end else if (launch) begin
      command_reg <= wdata16;
    end
  end

  // fields are taken from the launching write itself, not the stored copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg <= ITAP_DIR_WRITE;
    end else if (launch) begin
      dir_reg <= wdata16[ITAP_CMD_DIR_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= ITAP_TBL_STATIC;
    end else if (launch) begin
      sel_reg <= wdata16[ITAP_CMD_TBL_HI:ITAP_CMD_TBL_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_reg <= '0;
    end else if (launch) begin
      idx_reg <= wdata16[ITAP_CMD_IDX_HI:ITAP_CMD_IDX_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ITAP_IDLE;
    end else begin
      case (state_reg)
        ITAP_IDLE: begin
          if (launch) begin
            state_reg <= ITAP_WAIT;
          end
        end
        ITAP_WAIT: begin
          if (tbl_ack) begin
            state_reg <= ITAP_IDLE;
          end
        end
        default: begin
          state_reg <= ITAP_IDLE;
        end
      endcase
    end
  end

  // request mirrors the busy state: raised by a launch, dropped by the acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_reg <= 1'b0;
    end else if (launch & ~busy) begin
      req_reg <= 1'b1;
    end else if (busy & tbl_ack) begin
      req_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // read pending flag
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= 1'b0;
    end else if (launch) begin
      pending_reg <= (wdata16[ITAP_CMD_DIR_BIT] == ITAP_DIR_READ) &
        ((wdata16[ITAP_CMD_TBL_HI:ITAP_CMD_TBL_LO] == ITAP_TBL_DYNAMIC) |
         (wdata16[ITAP_CMD_TBL_HI:ITAP_CMD_TBL_LO] == ITAP_TBL_COUNTERS));
    end else if (rd_done) begin
      pending_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tbl_req = req_reg;
  assign tbl_dir_read = dir_reg;
  assign tbl_select = sel_reg;
  assign tbl_index = idx_reg;
  // staged data is stable for software that stages before launching
  assign tbl_wdata = {top_reg, d63_48_reg, d47_32_reg, d31_16_reg, d15_0_reg};

endmodule

// ****************************************************************
// one host-written staging slice that a finished read reloads
// ****************************************************************
module itap_stage_slice #(
  parameter int W = itap_pkg::ITAP_REG_W,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rd_load,
  input wire logic [W-1:0] rd_value,
  input wire logic wr_load,
  input wire logic [W-1:0] wr_value,
  output logic [W-1:0] value
);
  import itap_pkg::*;
  // a finished read beats a host write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= RESET_VALUE;
    end else if (rd_load) begin
      value <= rd_value;
    end else if (wr_load) begin
      value <= wr_value;
    end
  end
endmodule
`default_nettype wire

// *** tb/itap_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module itap_checker
  import itap_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ITAP_ADDR_W-1:0] paddr,
  input wire logic [ITAP_DATA_W-1:0] pwdata,
  input wire logic [ITAP_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tbl_req,
  input wire logic tbl_dir_read,
  input wire logic [1:0] tbl_select,
  input wire logic [ITAP_INDEX_W-1:0] tbl_index,
  input wire logic [ITAP_ENTRY_W-1:0] tbl_wdata,
  input wire logic tbl_ack,
  input wire logic [ITAP_ENTRY_W-1:0] tbl_rdata
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  wire logic hs = psel && penable && pready && !pslverr;
  wire logic cw = hs && pwrite && paddr == 12'h0C0;
  wire logic ld = tbl_req && tbl_ack && tbl_dir_read;
  wire logic rp = tbl_req && tbl_dir_read && tbl_select[1];
  wire logic st = psel && !penable && paddr == 12'h098;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_launch; cw |=> tbl_req; endproperty
  a_launch: assert property (p_launch) else $error("no access after command");
  property p_dir; cw |=> tbl_dir_read == $past(pwdata[12]); endproperty
  a_dir: assert property (p_dir) else $error("wrong direction");
  property p_sel; cw |=> tbl_select == $past(pwdata[11:10]); endproperty
  a_sel: assert property (p_sel) else $error("wrong table");
  property p_idx; cw |=> tbl_index == $past(pwdata[9:0]); endproperty
  a_idx: assert property (p_idx) else $error("wrong index");
  property p_pend; st && rp |=> pready && prdata[7]; endproperty
  a_pend: assert property (p_pend) else $error("pending bit low");
  property p_nopend; st && !rp |=> pready && !prdata[7]; endproperty
  a_nopend: assert property (p_nopend) else $error("pending bit high");
  // only a read load may move the top bits, host writes never do
  property p_top; !ld |=> $stable(tbl_wdata[66:64]); endproperty
  a_top: assert property (p_top) else $error("top bits changed");
  property p_load; ld |=> tbl_wdata == $past(tbl_rdata); endproperty
  a_load: assert property (p_load) else $error("entry not loaded");
  property p_wr32; hs && pwrite && paddr == 12'h0A0 && !ld |=>
    tbl_wdata[47:32] == $past(pwdata[15:0]); endproperty
  a_wr32: assert property (p_wr32) else $error("bits 47-32 not staged");
  property p_err; psel && !penable && paddr[1:0] != 2'h0 |=>
    pready && pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("misaligned access accepted");
  c_dyn: cover property (ld && tbl_select[1]);
  c_stall: cover property (psel && penable && !pready);
  c_err: cover property (pslverr);
endmodule
bind itap_indirect_table_access_port itap_checker itap_checker_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tbl_req(tbl_req),
  .tbl_dir_read(tbl_dir_read), .tbl_select(tbl_select), .tbl_index(tbl_index),
  .tbl_wdata(tbl_wdata), .tbl_ack(tbl_ack), .tbl_rdata(tbl_rdata));
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import itap_pkg::*;
  typedef struct {logic [15:0] c; logic [66:0] v;} itap_row_s;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tbl_ack = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, tbl_req, tbl_dir_read;
  logic [1:0] tbl_select;
  logic [9:0] tbl_index;
  logic [66:0] tbl_wdata, c_wd, tbl_rdata = 0, stg = 0;
  logic [15:0] c_cmd;
  int n_fail = 0, n_tests = 0, cyc = 0, cnt = 0, nl = 0, m;
  localparam logic [11:0] A[6] = '{12'h098, 12'h0A0, 12'h0A8, 12'h0B0, 12'h0B8, 12'h0C0};
  itap_row_s rows[6] = '{'{16'h0123, 67'h0_1111_2222_3333_4444},
    '{16'h1400, 67'h5_AAAA_BBBB_CCCC_DDDD}, '{16'h0BFF, 67'h0_0F0F_F0F0_1234_5678},
    '{16'h1A5A, 67'h7_0123_4567_89AB_CDEF}, '{16'h0C01, 67'h0_FFFF_0000_FFFF_0001},
    '{16'hFFFF, 67'h2_8000_0001_8000_0001}};
  itap_indirect_table_access_port itap_indirect_table_access_port_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tbl_req(tbl_req), .tbl_dir_read(tbl_dir_read), .tbl_select(tbl_select),
    .tbl_index(tbl_index), .tbl_wdata(tbl_wdata), .tbl_ack(tbl_ack), .tbl_rdata(tbl_rdata));
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ****************************************************************
  // table side: slow answer so the pending bit can be seen
  // ****************************************************************
  always @(posedge pclk) begin
    tbl_ack <= 1'b0;
    if (tbl_req && !tbl_ack) begin
      cnt <= cnt + 1;
      if (cnt == 4) begin
        tbl_ack <= 1'b1;
        cnt <= 0;
        nl <= nl + 1;
        c_cmd <= {3'h0, tbl_dir_read, tbl_select, tbl_index};
        c_wd <= tbl_wdata;
      end
    end else
      cnt <= 0;
  end
  task chk(input logic [66:0] s, input logic [66:0] x, input string nm);
    n_tests++;
    if (s !== x) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for the answer
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [15:0] sl(int j, logic [66:0] v);
    case (j)
      0: return {13'h0000, v[66:64]};
      1: return v[47:32];
      2: return v[63:48];
      3: return v[15:0];
      default: return v[31:16];
    endcase
  endfunction
  task wait_done();
    for (int k = 0; k < 50 && (nl == m || tbl_req); k++)
      @(posedge pclk);
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int j = 0; j < 6; j++) begin
      apb(0, A[j], 0);
      chk(r, 0, "reset value");
    end
    apb(1, 12'h099, 32'h1);
    chk({e, r}, 33'h100000000, "misaligned");
    apb(0, 12'h200, 0);
    chk({e, r}, 33'h100000000, "unmapped");
    apb(1, A[0], 32'h7);
    foreach (rows[i]) begin
      if (!rows[i].c[12]) begin
        for (int j = 1; j < 5; j++)
          apb(1, A[j], {16'h0000, sl(j, rows[i].v)});
        stg = {stg[66:64], rows[i].v[63:0]};
      end
      tbl_rdata <= rows[i].v;
      m = nl;
      apb(1, A[5], {16'h0000, rows[i].c});
      apb(0, A[0], 0);
      chk(r[7], rows[i].c[12] & rows[i].c[11], "pending");
      for (int k = 0; k < 20 && r[7]; k++)
        apb(0, A[0], 0);
      chk(r[7], 0, "pending cleared");
      wait_done();
      chk(nl - m, 1, "launches");
      chk(c_cmd, rows[i].c & 16'h1FFF, "fields");
      if (rows[i].c[12])
        stg = rows[i].v;
      else
        chk(c_wd, stg, "write entry");
      for (int j = 0; j < 5; j++) begin
        apb(0, A[j], 0);
        chk(r, sl(j, stg), "staged slice");
      end
      apb(0, A[5], 0);
      chk(r, rows[i].c, "command");
    end
    // second command waits for the first instead of being dropped
    m = nl;
    apb(1, A[5], 32'h1800);
    apb(1, A[5], 32'h0400);
    wait_done();
    chk(nl - m, 2, "back to back");
    chk(c_cmd, 16'h0400, "second fields");
    apb(1, A[5], 32'h1C00);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(tbl_req, 0, "request in reset");
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, A[0], 0);
    chk(r, 0, "status after reset");
    give_verdict();
  end
endmodule
`default_nettype wire
